// ==== src/bulk_ep_engine.sv ====
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module bulk_ep_engine (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic bus_reset,
    input bulk_ep_pkg::token_t tok,
    input bulk_ep_pkg::rx_t rx,
    input bulk_ep_pkg::host_resp_t host,
    input wire logic tx_ready,
    output bulk_ep_pkg::tx_t tx,
    output bulk_ep_pkg::hs_t hs,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] in_irq_req,
    output logic [7:0] out_irq_req
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_tx = 2'b01,
        st_wait = 2'b11,
        st_rx = 2'b10
    } link_st_t;

    typedef struct packed {
        link_st_t st;
        logic [2:0] ep;
        logic [2:0] slot;
        logic [6:0] idx;
        logic drop;
        logic over;
        bulk_ep_pkg::tx_t tx;
        bulk_ep_pkg::hs_t hs;
        logic [7:0] rdata;
        logic [7:0] in_armed;
        logic [7:0] out_armed;
        logic [7:0] in_stall;
        logic [7:0] out_stall;
        logic [7:0] in_tog;
        logic [7:0] out_tog;
        logic [7:0] in_irq;
        logic [7:0] out_irq;
        logic [7:0] in_valid;
        logic [7:0] out_valid;
        logic [7:0][6:0] in_len;
        logic [7:0][6:0] out_len;
        logic [5:0] pairing;
        logic [2:0] in_fw_sel;
        logic [2:0] in_host_sel;
        logic [2:0] out_fw_sel;
        logic [2:0] out_host_sel;
    } state_t;

    localparam state_t STATE_RST = '{
        st: st_idle,
        in_armed: bulk_ep_pkg::IN_ARMED_RST,
        out_armed: bulk_ep_pkg::OUT_ARMED_RST,
        in_valid: bulk_ep_pkg::VALID_RST,
        out_valid: bulk_ep_pkg::VALID_RST,
        default: '0
    };

    state_t s;
    state_t next_s;

    // endpoint buffers: {dir, slot, byte}, dir 1 is OUT
    logic [7:0] mem [bulk_ep_pkg::MEM_WORDS];

    // ****************************************************************
    // pairing helpers
    // ****************************************************************
    function automatic logic is_pair(input logic [2:0] ep, input logic [2:0] prs);
        logic [3:0] pr4;
        pr4 = {prs, 1'b0};
        is_pair = !ep[0] && pr4[ep[2:1]];
    endfunction

    // even endpoint of a pair maps onto one of its two physical buffers
    function automatic logic [2:0] slot_of(input logic [2:0] ep, input logic [2:0] prs,
                                           input logic [2:0] sel);
        logic [3:0] sel4;
        sel4 = {sel, 1'b0};
        slot_of = is_pair(ep, prs) ? {ep[2:1], sel4[ep[2:1]]} : ep;
    endfunction

    // paired: busy only when both halves are armed
    function automatic logic busy_of(input logic [2:0] ep, input logic [2:0] prs,
                                     input logic [7:0] armed);
        if (is_pair(ep, prs)) begin
            busy_of = armed[{ep[2:1], 1'b0}] && armed[{ep[2:1], 1'b1}];
        end else begin
            busy_of = armed[ep];
        end
    endfunction

    function automatic logic [2:0] flip_sel(input logic [2:0] ep, input logic [2:0] prs,
                                            input logic [2:0] sel);
        logic [1:0] p;
        p = ep[2:1] - 2'h1;
        flip_sel = is_pair(ep, prs) ? (sel ^ (3'h1 << p)) : sel;
    endfunction

    // ****************************************************************
    // firmware side decode
    // ****************************************************************
    logic [2:0] fw_ep;
    logic [2:0] fw_in_slot;
    logic [2:0] fw_out_slot;
    logic fw_buf;
    logic [2:0] fw_buf_slot;
    logic [9:0] fw_maddr;
    logic fw_we;
    logic rx_we;
    logic [9:0] rx_waddr;

    assign fw_ep = reg_addr[2:0];
    assign fw_in_slot = slot_of(fw_ep, s.pairing[2:0], s.in_fw_sel);
    assign fw_out_slot = slot_of(fw_ep, s.pairing[5:3], s.out_fw_sel);
    assign fw_buf = reg_addr[11:10] == 2'b00;
    assign fw_buf_slot = reg_addr[9] ?
        slot_of(reg_addr[8:6], s.pairing[5:3], s.out_fw_sel) :
        slot_of(reg_addr[8:6], s.pairing[2:0], s.in_fw_sel);
    assign fw_maddr = {reg_addr[9], fw_buf_slot, reg_addr[5:0]};
    // firmware keeps off busy buffers, but both share one write port: in a receive byte's cycle the firmware write is lost
    assign fw_we = reg_wr && fw_buf;
    // packets for a stalled endpoint or unarmed buffer never reach the buffer
    assign rx_we = (s.st == st_rx) && !s.drop && rx.valid && (s.idx < bulk_ep_pkg::BUF_BYTES);
    assign rx_waddr = {1'b1, s.slot, s.idx[5:0]};

    always_ff @(posedge ref_clk) begin
        if (rx_we) begin
            mem[rx_waddr] <= rx.data;
        end else if (fw_we) begin
            mem[fw_maddr] <= reg_wdata;
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [7:0] rd_val;
        logic [6:0] nxt;
        logic [6:0] wlen;
        logic [2:0] hslot;
        logic ep_ok;
        rd_val = 8'h00;
        nxt = s.idx + 7'h01;
        wlen = (reg_wdata[6:0] > bulk_ep_pkg::BUF_BYTES) ? bulk_ep_pkg::BUF_BYTES :
            reg_wdata[6:0];
        hslot = 3'h0;
        ep_ok = 1'b0;
        next_s = s;
        next_s.hs.valid = 1'b0;
        next_s.tx.start = 1'b0;

        // register reads: data stands in the following cycle only
        if (fw_buf) begin
            rd_val = mem[fw_maddr];
        end else begin
            case (reg_addr[11:3])
                bulk_ep_pkg::IN_LEN_BASE[11:3]: rd_val = {1'b0, s.in_len[fw_in_slot]};
                bulk_ep_pkg::OUT_LEN_BASE[11:3]: rd_val = {1'b0, s.out_len[fw_out_slot]};
                bulk_ep_pkg::IN_CS_BASE[11:3]: begin
                    rd_val[bulk_ep_pkg::CS_STALL_BIT] = s.in_stall[fw_ep];
                    rd_val[bulk_ep_pkg::CS_BUSY_BIT] =
                        busy_of(fw_ep, s.pairing[2:0], s.in_armed);
                end
                bulk_ep_pkg::OUT_CS_BASE[11:3]: begin
                    rd_val[bulk_ep_pkg::CS_STALL_BIT] = s.out_stall[fw_ep];
                    rd_val[bulk_ep_pkg::CS_BUSY_BIT] =
                        busy_of(fw_ep, s.pairing[5:3], s.out_armed);
                end
                bulk_ep_pkg::MISC_BASE[11:3]: begin
                    case (reg_addr[2:0])
                        bulk_ep_pkg::IN_VALID_OFS: rd_val = s.in_valid;
                        bulk_ep_pkg::OUT_VALID_OFS: rd_val = s.out_valid;
                        bulk_ep_pkg::PAIRING_OFS: rd_val = {2'b00, s.pairing};
                        bulk_ep_pkg::IN_IRQ_OFS: rd_val = s.in_irq;
                        bulk_ep_pkg::OUT_IRQ_OFS: rd_val = s.out_irq;
                        default: rd_val = 8'h00;
                    endcase
                end
                default: rd_val = 8'h00;
            endcase
        end
        next_s.rdata = reg_rd ? rd_val : 8'h00;

        // register writes come first so a same-cycle hardware set wins
        if (reg_wr && !fw_buf) begin
            case (reg_addr[11:3])
                bulk_ep_pkg::IN_LEN_BASE[11:3]: begin
                    next_s.in_len[fw_in_slot] = wlen;
                    next_s.in_armed[fw_in_slot] = 1'b1;
                    next_s.in_fw_sel = flip_sel(fw_ep, s.pairing[2:0], s.in_fw_sel);
                end
                bulk_ep_pkg::OUT_LEN_BASE[11:3]: begin
                    // value written is irrelevant
                    next_s.out_armed[fw_out_slot] = 1'b1;
                    next_s.out_fw_sel = flip_sel(fw_ep, s.pairing[5:3], s.out_fw_sel);
                end
                bulk_ep_pkg::IN_CS_BASE[11:3]:
                    next_s.in_stall[fw_ep] = reg_wdata[bulk_ep_pkg::CS_STALL_BIT];
                bulk_ep_pkg::OUT_CS_BASE[11:3]:
                    next_s.out_stall[fw_ep] = reg_wdata[bulk_ep_pkg::CS_STALL_BIT];
                bulk_ep_pkg::MISC_BASE[11:3]: begin
                    case (reg_addr[2:0])
                        bulk_ep_pkg::IN_VALID_OFS:
                            next_s.in_valid = reg_wdata | bulk_ep_pkg::VALID_RST;
                        bulk_ep_pkg::OUT_VALID_OFS:
                            next_s.out_valid = reg_wdata | bulk_ep_pkg::VALID_RST;
                        bulk_ep_pkg::PAIRING_OFS: next_s.pairing = reg_wdata[5:0];
                        bulk_ep_pkg::IN_IRQ_OFS: next_s.in_irq = s.in_irq & ~reg_wdata;
                        bulk_ep_pkg::OUT_IRQ_OFS: next_s.out_irq = s.out_irq & ~reg_wdata;
                        default: next_s.pairing = next_s.pairing;
                    endcase
                end
                default: next_s.pairing = next_s.pairing;
            endcase
        end

        // ****************************************************************
        // link side: bulk and interrupt endpoints share one path
        // ****************************************************************
        unique case (s.st)
            st_idle: begin
                if (tok.valid) begin
                    ep_ok = tok.dir_in ? s.in_valid[tok.ep] : s.out_valid[tok.ep];
                end
                // unknown endpoint: silence, no state touched
                if (tok.valid && ep_ok) begin
                    next_s.ep = tok.ep;
                    next_s.idx = 7'h00;
                    if (tok.dir_in) begin
                        hslot = slot_of(tok.ep, s.pairing[2:0], s.in_host_sel);
                        next_s.slot = hslot;
                        if (s.in_stall[tok.ep]) begin
                            next_s.hs.valid = 1'b1;
                            next_s.hs.code = bulk_ep_pkg::hs_stall;
                        end else if (!s.in_armed[hslot]) begin
                            next_s.hs.valid = 1'b1;
                            next_s.hs.code = bulk_ep_pkg::hs_nak;
                        end else begin
                            next_s.tx.start = 1'b1;
                            next_s.tx.len = s.in_len[hslot];
                            next_s.tx.data1 = s.in_tog[tok.ep];
                            next_s.tx.data = mem[{1'b0, hslot, 6'h00}];
                            next_s.tx.valid = s.in_len[hslot] != 7'h00;
                            next_s.tx.last = s.in_len[hslot] == 7'h01;
                            next_s.st = (s.in_len[hslot] == 7'h00) ? st_wait : st_tx;
                        end
                    end else begin
                        hslot = slot_of(tok.ep, s.pairing[5:3], s.out_host_sel);
                        next_s.slot = hslot;
                        next_s.over = 1'b0;
                        next_s.drop = s.out_stall[tok.ep] || !s.out_armed[hslot];
                        next_s.st = st_rx;
                    end
                end
            end
            st_tx: begin
                if (s.tx.valid && tx_ready) begin
                    next_s.idx = nxt;
                    if (nxt == s.tx.len) begin
                        next_s.tx.valid = 1'b0;
                        next_s.tx.last = 1'b0;
                        next_s.st = st_wait;
                    end else begin
                        next_s.tx.data = mem[{1'b0, s.slot, nxt[5:0]}];
                        next_s.tx.last = (nxt + 7'h01) == s.tx.len;
                    end
                end
            end
            st_wait: begin
                if (host.ack) begin
                    next_s.in_armed[s.slot] = 1'b0;
                    next_s.in_irq[s.ep] = 1'b1;
                    next_s.in_tog[s.ep] = !s.in_tog[s.ep];
                    next_s.in_host_sel = flip_sel(s.ep, s.pairing[2:0], s.in_host_sel);
                    next_s.st = st_idle;
                end else if (host.timeout) begin
                    // still armed, the next token replays the same buffer
                    next_s.st = st_idle;
                end
            end
            st_rx: begin
                if (rx.valid) begin
                    if (s.idx == bulk_ep_pkg::BUF_BYTES) begin
                        next_s.over = 1'b1;
                    end else begin
                        next_s.idx = nxt;
                    end
                end
                if (rx.done) begin
                    next_s.st = st_idle;
                    // corrupt or oversized packet: stay quiet, host retries
                    if (rx.ok && !s.over) begin
                        next_s.hs.valid = 1'b1;
                        if (s.out_stall[s.ep]) begin
                            next_s.hs.code = bulk_ep_pkg::hs_stall;
                        end else if (!s.out_armed[s.slot]) begin
                            next_s.hs.code = bulk_ep_pkg::hs_nak;
                        end else if (rx.data1 != s.out_tog[s.ep]) begin
                            // repeat of a packet already taken: ack, length and armed bit unchanged, though its bytes were written
                            next_s.hs.code = bulk_ep_pkg::hs_ack;
                        end else begin
                            next_s.hs.code = bulk_ep_pkg::hs_ack;
                            next_s.out_len[s.slot] = s.idx;
                            next_s.out_armed[s.slot] = 1'b0;
                            next_s.out_irq[s.ep] = 1'b1;
                            next_s.out_tog[s.ep] = !s.out_tog[s.ep];
                            next_s.out_host_sel =
                                flip_sel(s.ep, s.pairing[5:3], s.out_host_sel);
                        end
                    end
                end
            end
        endcase

        // bus reset: valid bits, pairing and requests are left alone
        if (bus_reset) begin
            next_s.st = st_idle;
            next_s.tx = '0;
            next_s.hs = '0;
            next_s.in_armed = bulk_ep_pkg::IN_ARMED_RST;
            next_s.out_armed = bulk_ep_pkg::OUT_ARMED_RST;
            next_s.in_tog = 8'h00;
            next_s.out_tog = 8'h00;
            next_s.in_fw_sel = 3'h0;
            next_s.in_host_sel = 3'h0;
            next_s.out_fw_sel = 3'h0;
            next_s.out_host_sel = 3'h0;
            next_s.in_valid = s.in_valid;
            next_s.out_valid = s.out_valid;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign tx = s.tx;
    assign hs = s.hs;
    assign reg_rdata = s.rdata;
    assign in_irq_req = s.in_irq;
    assign out_irq_req = s.out_irq;

endmodule // bulk_ep_engine

// ==== src/bulk_ep_pkg.sv ====
// ****************************************************************
// sizes, offsets, reset values
// ****************************************************************
package bulk_ep_pkg;

    localparam int EP_COUNT = 8;
    localparam int LEN_W = 7;
    localparam int ADDR_W = 12;
    localparam int MEM_AW = 10;
    localparam int MEM_WORDS = 1024;
    localparam logic [6:0] BUF_BYTES = 7'h40;

    // register map, byte addressed, 8-bit data
    localparam logic [11:0] IN_LEN_BASE = 12'h400;
    localparam logic [11:0] OUT_LEN_BASE = 12'h408;
    localparam logic [11:0] IN_CS_BASE = 12'h410;
    localparam logic [11:0] OUT_CS_BASE = 12'h418;
    localparam logic [11:0] MISC_BASE = 12'h420;
    localparam logic [2:0] IN_VALID_OFS = 3'h0;
    localparam logic [2:0] OUT_VALID_OFS = 3'h1;
    localparam logic [2:0] PAIRING_OFS = 3'h2;
    localparam logic [2:0] IN_IRQ_OFS = 3'h3;
    localparam logic [2:0] OUT_IRQ_OFS = 3'h4;

    // control/status fields
    localparam int CS_STALL_BIT = 0;
    localparam int CS_BUSY_BIT = 1;
    localparam int PAIR_IN_POS = 0;
    localparam int PAIR_OUT_POS = 3;

    // values after reset
    localparam logic [7:0] VALID_RST = 8'h01;
    localparam logic [7:0] IN_ARMED_RST = 8'h00;
    localparam logic [7:0] OUT_ARMED_RST = 8'hFF;

    typedef enum logic [1:0] {
        hs_ack = 2'h0,
        hs_nak = 2'h1,
        hs_stall = 2'h2
    } hs_code_t;

    typedef struct packed {
        logic valid;
        logic dir_in;
        logic [2:0] ep;
    } token_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic done;
        logic ok;
        logic data1;
    } rx_t;

    typedef struct packed {
        logic ack;
        logic timeout;
    } host_resp_t;

    typedef struct packed {
        logic start;
        logic data1;
        logic [6:0] len;
        logic valid;
        logic [7:0] data;
        logic last;
    } tx_t;

    typedef struct packed {
        logic valid;
        hs_code_t code;
    } hs_t;

endpackage

// ==== verif/bulk_ep_engine_chk.sv ====
`timescale 1ns/1ps
// ****
// link and register port checks
// ****
module bulk_ep_engine_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic bus_reset,
    input bulk_ep_pkg::token_t tok,
    input bulk_ep_pkg::rx_t rx,
    input bulk_ep_pkg::host_resp_t host,
    input wire logic tx_ready,
    input bulk_ep_pkg::tx_t tx,
    input bulk_ep_pkg::hs_t hs,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] in_irq_req,
    input wire logic [7:0] out_irq_req
);
    default clocking @(posedge ref_clk);
    endclocking
    // bus reset idles the link, so link relations restart with it
    default disable iff (!rstn || bus_reset);
    a_rd_slot: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("stray read data");
    a_hs_pulse: assert property (hs.valid |=> !hs.valid)
        else $error("handshake longer than one cycle");
    a_hs_cause: assert property (hs.valid |-> $past(tok.valid) || $past(rx.done))
        else $error("handshake without token or packet end");
    a_nak_no_data: assert property (hs.valid |-> !tx.start && !tx.valid)
        else $error("data beside a handshake");
    a_start_cause: assert property (tx.start |-> $past(tok.valid && tok.dir_in))
        else $error("packet without in token");
    a_start_len: assert property (tx.start |-> tx.len <= 7'h40)
        else $error("packet longer than buffer");
    a_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("byte dropped while stalled");
    a_in_irq_cause: assert property ((in_irq_req & ~$past(in_irq_req)) != 8'h00
        |-> $past(host.ack))
        else $error("in request without host ack");
    a_out_irq_cause: assert property ((out_irq_req & ~$past(out_irq_req)) != 8'h00
        |-> hs.valid && hs.code == bulk_ep_pkg::hs_ack)
        else $error("out request without ack");
    c_data: cover property (tx.valid && tx.last && tx_ready);
    c_nak: cover property (hs.valid && hs.code == bulk_ep_pkg::hs_nak);
    c_stall: cover property (hs.valid && hs.code == bulk_ep_pkg::hs_stall);
endmodule // bulk_ep_engine_chk

bind bulk_ep_engine bulk_ep_engine_chk u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .bus_reset(bus_reset), .tok(tok), .rx(rx),
    .host(host), .tx_ready(tx_ready), .tx(tx), .hs(hs), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_irq_req(in_irq_req), .out_irq_req(out_irq_req)
);

// ==== verif/usb_host_model.sv ====
`timescale 1ns/1ps
// ****
// host side of the link
// ****
module usb_host_model (
    input wire logic ref_clk,
    input bulk_ep_pkg::tx_t tx,
    input bulk_ep_pkg::hs_t hs,
    output bulk_ep_pkg::token_t tok,
    output bulk_ep_pkg::rx_t rx,
    output bulk_ep_pkg::host_resp_t host,
    output logic tx_ready
);
    integer seed = 65334;
    logic [7:0] tog = 8'h00;
    initial begin
        tok = '0;
        rx = '0;
        host = '0;
    end
    // random stalls make the device hold its byte
    always @(posedge ref_clk) begin
        tx_ready <= 1'($random(seed));
    end
    task automatic in_xfer(input logic [2:0] ep, input logic ack);
        int n;
        @(posedge ref_clk);
        tok <= {1'b1, 1'b1, ep};
        @(posedge ref_clk);
        tok.valid <= 1'b0;
        n = 0;
        // an ignored token gets no answer, so the wait is bounded
        while (n < 60 && !hs.valid && !(tx.valid && tx_ready && tx.last)) begin
            @(posedge ref_clk);
            n++;
        end
        if (n < 60 && !hs.valid) begin
            host <= {ack, !ack};
            @(posedge ref_clk);
            host <= 2'b00;
        end
    endtask
    task automatic out_xfer(input logic [2:0] ep, input logic [7:0] b, input int len,
            input logic ok);
        @(posedge ref_clk);
        tok <= {1'b1, 1'b0, ep};
        for (int k = 0; k < len; k++) begin
            @(posedge ref_clk);
            tok.valid <= 1'b0;
            rx <= {1'b1, b + 8'(k), 3'b000};
        end
        @(posedge ref_clk);
        // released data line shows the inverse, never the last byte
        rx <= {1'b0, ~rx.data, 1'b1, ok, tog[ep]};
        @(posedge ref_clk);
        rx.done <= 1'b0;
        @(posedge ref_clk);
        if (hs.valid && hs.code == bulk_ep_pkg::hs_ack) tog[ep] = ~tog[ep];
    endtask
endmodule // usb_host_model

// ==== verif/bulk_ep_engine_tb.sv ====
`timescale 1ns/1ps
module bulk_ep_engine_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic bus_reset;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata, in_irq_req, out_irq_req, base;
    logic [7:0] inbuf [4];
    bulk_ep_pkg::token_t tok;
    bulk_ep_pkg::rx_t rx;
    bulk_ep_pkg::host_resp_t host;
    bulk_ep_pkg::tx_t tx;
    bulk_ep_pkg::hs_t hs;
    logic tx_ready;
    logic rd_d = 1'b0;
    logic [9:0] expq [$];
    int bad_count = 0;
    int tests_run = 0;
    integer seed = 65334;
    always #25 ref_clk = ~ref_clk;
    bulk_ep_engine u_dut (.ref_clk(ref_clk), .rstn(rstn), .bus_reset(bus_reset), .tok(tok),
        .rx(rx), .host(host), .tx_ready(tx_ready), .tx(tx), .hs(hs), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_irq_req(in_irq_req), .out_irq_req(out_irq_req));
    usb_host_model u_host (.ref_clk(ref_clk), .tx(tx), .hs(hs), .tok(tok), .rx(rx),
        .host(host), .tx_ready(tx_ready));
    // ****
    // comparison and verdict
    // ****
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // an event with nothing noted is itself a fault
    task automatic note(input logic [9:0] got);
        if (expq.size() == 0) check(got, 10'h3FF);
        else check(got, expq.pop_front());
    endtask
    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        if (rd_d) note({2'h0, reg_rdata});
        if (hs.valid) note({2'h1, 6'h00, hs.code});
        if (tx.valid && tx_ready) note({2'h2, tx.data});
    end
    // ****
    // register port
    // ****
    // strobes stay up until the next access or idle, one assignment per edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        expq.push_back({2'h0, e});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic idle();
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        summarize();
    end
    // ****
    // scenarios; buffers touched only while not busy
    // ****
    initial begin
        bus_reset <= 1'b0;
        reg_addr <= 12'h000;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        base = 8'($random(seed));
        u_host.in_xfer(3'h2, 1'b1);
        rd(12'h420, 8'h01);
        bus(1'b1, 12'h420, 8'hFF);
        bus(1'b1, 12'h421, 8'hFF);
        idle();
        expq.push_back(10'h101);
        u_host.in_xfer(3'h2, 1'b1);
        for (int k = 0; k < 4; k++) begin
            inbuf[k] = 8'($random(seed));
            bus(1'b1, 12'h080 + 12'(k), inbuf[k]);
        end
        bus(1'b1, 12'h402, 8'h04);
        rd(12'h412, 8'h02);
        idle();
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) expq.push_back({2'h2, inbuf[k]});
            u_host.in_xfer(3'h2, 1'(p));
        end
        rd(12'h412, 8'h00);
        rd(12'h423, 8'h04);
        check({2'h0, in_irq_req}, 10'h004);
        bus(1'b1, 12'h423, 8'h04);
        rd(12'h423, 8'h00);
        bus(1'b1, 12'h413, 8'h01);
        rd(12'h413, 8'h01);
        idle();
        expq.push_back(10'h101);
        u_host.in_xfer(3'h2, 1'b1);
        expq.push_back(10'h102);
        u_host.in_xfer(3'h3, 1'b1);
        expq.push_back(10'h100);
        u_host.out_xfer(3'h4, base, 3, 1'b1);
        rd(12'h40C, 8'h03);
        rd(12'h41C, 8'h00);
        rd(12'h424, 8'h10);
        check({2'h0, out_irq_req}, 10'h010);
        idle();
        expq.push_back(10'h101);
        u_host.out_xfer(3'h4, ~base, 5, 1'b1);
        rd(12'h302, base + 8'h02);
        bus(1'b1, 12'h40C, 8'($random(seed)));
        rd(12'h41C, 8'h02);
        idle();
        u_host.out_xfer(3'h4, ~base, 5, 1'b0);
        expq.push_back(10'h100);
        u_host.out_xfer(3'h4, ~base, 5, 1'b1);
        rd(12'h40C, 8'h05);
        bus(1'b1, 12'h402, 8'h01);
        idle();
        @(posedge ref_clk);
        bus_reset <= 1'b1;
        @(posedge ref_clk);
        bus_reset <= 1'b0;
        rd(12'h420, 8'hFF);
        rd(12'h412, 8'h00);
        idle();
        expq.push_back(10'h101);
        u_host.in_xfer(3'h2, 1'b1);
        // chip reset in mid-run: requests cleared, only endpoint zero valid
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        check({2'h0, in_irq_req | out_irq_req}, 10'h000);
        rd(12'h420, 8'h01);
        rd(12'h41C, 8'h02);
        idle();
        u_host.in_xfer(3'h2, 1'b1);
        repeat (4) @(posedge ref_clk);
        check(10'(expq.size()), 10'h000);
        summarize();
    end
endmodule // bulk_ep_engine_tb
